// ### atss_pkg.sv
// Purpose: Shared constants, types and helpers for the absolute time source block.
// Assumes: 125 MHz system clock; parsed NMEA and PTP servo results arrive on that clock.
// Notes: Log interval periods are expressed in units of 1/128 second.
package atss_pkg;

  // ==========================================================================
  // Timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int US_PERIOD_NS = 1000;
  localparam int CYC_PER_US = (US_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int US_PER_SEC_DEF = 1000000;

  // ==========================================================================
  // Widths
  localparam int SECS_W = 32;
  localparam int US_W = 20;
  localparam int PORT_W = 16;
  localparam int DOM_W = 7;
  localparam int LIM_W = 7;
  localparam int OFS_W = 16;
  localparam int EXP_W = 4;
  localparam int PER_W = 11;

  // ==========================================================================
  // Reset values and ranges
  localparam logic [PORT_W-1:0] GPS_PORT_RST = 16'h277e;
  localparam logic [DOM_W-1:0] DOMAIN_RST = 7'h00;
  localparam logic [LIM_W-1:0] LOCK_LIM_RST = 7'h01;
  localparam logic [LIM_W-1:0] LOCK_LIM_MIN = 7'h01;
  localparam logic [LIM_W-1:0] LOCK_LIM_MAX = 7'h64;
  localparam logic signed [EXP_W-1:0] ANN_MIN = 4'he;
  localparam logic signed [EXP_W-1:0] ANN_MAX = 4'h3;
  localparam logic signed [EXP_W-1:0] ANN_RST = 4'h1;
  localparam logic signed [EXP_W-1:0] SYNC_MIN = 4'h9;
  localparam logic signed [EXP_W-1:0] SYNC_MAX = 4'h3;
  localparam logic signed [EXP_W-1:0] SYNC_RST = 4'h1;
  localparam logic signed [EXP_W-1:0] DREQ_MIN = 4'h9;
  localparam logic signed [EXP_W-1:0] DREQ_MAX = 4'h3;
  localparam logic signed [EXP_W-1:0] DREQ_RST = 4'h0;
  localparam logic signed [4:0] PER_EXP_BIAS = 5'h07;

  // ==========================================================================
  // Types
  typedef enum logic {SRC_GPS, SRC_PTP} atss_src_t;
  typedef enum logic {NMEA_RMC, NMEA_GGA} atss_nmea_t;
  typedef enum logic {PROF_1588V2, PROF_8021AS} atss_prof_t;
  typedef enum logic {XPORT_UDP, XPORT_L2} atss_xport_t;

  typedef struct packed {
    atss_src_t src;
    atss_nmea_t nmea_fmt;
    logic pulse_lock_required;
    logic [PORT_W-1:0] gps_port;
    atss_prof_t profile;
    atss_xport_t transport;
    logic [DOM_W-1:0] domain;
    logic [LIM_W-1:0] lock_limit_us;
    logic signed [EXP_W-1:0] log_announce;
    logic signed [EXP_W-1:0] log_sync;
    logic signed [EXP_W-1:0] log_dreq;
  } atss_cfg_t;

  typedef struct packed {
    atss_prof_t profile;
    atss_xport_t transport;
    logic [DOM_W-1:0] domain;
    logic [LIM_W-1:0] lock_limit_us;
    logic [PER_W-1:0] announce_period;
    logic [PER_W-1:0] sync_period;
    logic [PER_W-1:0] dreq_period;
  } atss_ptp_cfg_t;

  localparam atss_cfg_t CFG_RST = '{
    src: SRC_GPS, nmea_fmt: NMEA_RMC, pulse_lock_required: 1'b1,
    gps_port: GPS_PORT_RST, profile: PROF_1588V2, transport: XPORT_UDP,
    domain: DOMAIN_RST, lock_limit_us: LOCK_LIM_RST, log_announce: ANN_RST,
    log_sync: SYNC_RST, log_dreq: DREQ_RST};

  // ==========================================================================
  // Helpers
  function automatic logic signed [EXP_W-1:0] atss_clamp_exp(
      input logic signed [EXP_W-1:0] v,
      input logic signed [EXP_W-1:0] lo,
      input logic signed [EXP_W-1:0] hi);
    return (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : atss_clamp_exp

  // Period of 2^n seconds in 1/128 s units
  function automatic logic [PER_W-1:0] atss_period(input logic signed [EXP_W-1:0] e);
    logic signed [4:0] s;
    s = {e[EXP_W-1], e} + PER_EXP_BIAS;
    return 11'h001 << s[3:0];
  endfunction : atss_period

endpackage : atss_pkg

// ### atss_tick_div.sv
// Purpose: Divider that emits a one-cycle enable every DIV clock cycles.
// Assumes: DIV of at least 2.
// Notes: Output comes from a flip-flop.
`timescale 1ns/1ps
module atss_tick_div
  import atss_pkg::*;
#(
  parameter int DIV = CYC_PER_US
) (
  input wire logic i_clk,
  input wire logic i_rst,
  output logic o_tick
);

  localparam int CW = $clog2(DIV);
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  logic [CW-1:0] cnt_reg;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cnt_reg <= '0;
      o_tick <= 1'b0;
    end else begin
      o_tick <= (cnt_reg == LAST);
      cnt_reg <= (cnt_reg == LAST) ? '0 : cnt_reg + 1'b1;
    end
  end

endmodule : atss_tick_div

// ### atss_time_core.sv
// Purpose: Absolute system time keeper with GPS or PTP source selection.
// Assumes: NMEA parser and PTP servo run on i_clk; the PPS pin is asynchronous.
// Notes: Function
// Function
// - Select GPS or PTP source, GPS after reset
// - Accept only sentences of configured NMEA format
// - PPS locked: microseconds restart on each pulse
// - Both locked: load date and time from NMEA
// - PPS unlocked: load only if lock not required
// - Keep whole seconds plus separate microsecond field
// - GPS packets to configurable port, reset 10110
// - PTP source suppresses GPS data packets
// - PTP locked while offset within 1..100 limit
// - UDP transport only with 1588v2 profile
// - PTP domain 0 to 127, reset 0
// - Announce exponent -2..3, default 1
// - Sync exponent -7..3, default 1
// - Delay request exponent -7..3, default 0
// - GPS locked: PPS rising edge marks second
// - Nothing locked: internal one-hertz marks second
`timescale 1ns/1ps
module atss_time_core
  import atss_pkg::*;
#(
  parameter int US_PER_SEC = US_PER_SEC_DEF
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_cfg_wr,
  input wire atss_cfg_t i_cfg,
  input wire logic i_pps,
  input wire logic i_pps_locked,
  input wire logic i_nmea_locked,
  input wire logic i_nmea_valid,
  input wire atss_nmea_t i_nmea_kind,
  input wire logic [SECS_W-1:0] i_nmea_secs,
  input wire logic i_ptp_ofs_valid,
  input wire logic [OFS_W-1:0] i_ptp_ofs_abs_us,
  input wire logic i_ptp_sec_pulse,
  output atss_src_t o_src,
  output atss_nmea_t o_nmea_fmt,
  output logic [SECS_W-1:0] o_sys_secs,
  output logic [US_W-1:0] o_sys_us,
  output logic o_full_second,
  output logic o_gps_pkt_en,
  output logic [PORT_W-1:0] o_gps_port,
  output logic o_ptp_locked,
  output atss_ptp_cfg_t o_ptp_cfg
);

  localparam logic [US_W-1:0] US_MAX = US_W'(US_PER_SEC - 1);

  // ==========================================================================
  // Configuration store
  atss_cfg_t cfg_reg;
  atss_cfg_t cfg_next;

  always_comb begin
    cfg_next = i_cfg;
    // Out-of-range limits are pulled to the nearest legal value
    if (i_cfg.lock_limit_us < LOCK_LIM_MIN) begin
      cfg_next.lock_limit_us = LOCK_LIM_MIN;
    end else if (i_cfg.lock_limit_us > LOCK_LIM_MAX) begin
      cfg_next.lock_limit_us = LOCK_LIM_MAX;
    end
    if (i_cfg.profile != PROF_1588V2) begin
      cfg_next.transport = XPORT_L2;
    end
    cfg_next.log_announce = atss_clamp_exp(i_cfg.log_announce, ANN_MIN, ANN_MAX);
    cfg_next.log_sync = atss_clamp_exp(i_cfg.log_sync, SYNC_MIN, SYNC_MAX);
    cfg_next.log_dreq = atss_clamp_exp(i_cfg.log_dreq, DREQ_MIN, DREQ_MAX);
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cfg_reg <= CFG_RST;
    end else if (i_cfg_wr) begin
      cfg_reg <= cfg_next;
    end
  end

  // ==========================================================================
  // PPS synchroniser and edge detect
  logic pps_meta_reg;
  logic pps_sync_reg;
  logic pps_prev_reg;
  logic pps_rise;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pps_meta_reg <= 1'b0;
      pps_sync_reg <= 1'b0;
      pps_prev_reg <= 1'b0;
    end else begin
      pps_meta_reg <= i_pps;
      pps_sync_reg <= pps_meta_reg;
      pps_prev_reg <= pps_sync_reg;
    end
  end

  assign pps_rise = pps_sync_reg & ~pps_prev_reg;

  // ==========================================================================
  // Microsecond tick
  logic us_tick;

  atss_tick_div #(
    .DIV(CYC_PER_US)
  ) u_us_div (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .o_tick(us_tick)
  );

  // ==========================================================================
  // PTP lock status
  logic ptp_locked_reg;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ptp_locked_reg <= 1'b0;
    end else begin
      ptp_locked_reg <= (cfg_reg.src == SRC_PTP) && i_ptp_ofs_valid &&
          (i_ptp_ofs_abs_us <= OFS_W'(cfg_reg.lock_limit_us));
    end
  end

  // ==========================================================================
  // Full-second boundary selection
  logic gps_pps_mode;
  logic ptp_mode;
  logic us_wrap;
  logic boundary;
  logic nmea_load;

  assign gps_pps_mode = (cfg_reg.src == SRC_GPS) && i_pps_locked;
  assign ptp_mode = (cfg_reg.src == SRC_PTP) && ptp_locked_reg;
  assign us_wrap = us_tick && (o_sys_us == US_MAX);

  always_comb begin
    if (gps_pps_mode) begin
      boundary = pps_rise;
    end else if (ptp_mode) begin
      boundary = i_ptp_sec_pulse;
    end else begin
      boundary = us_wrap;
    end
  end

  // Date and time load from NMEA under the lock decision table
  assign nmea_load = (cfg_reg.src == SRC_GPS) && i_nmea_valid &&
      (i_nmea_kind == cfg_reg.nmea_fmt) && i_nmea_locked &&
      (i_pps_locked || !cfg_reg.pulse_lock_required);

  // ==========================================================================
  // System time
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_sys_us <= '0;
    end else if (boundary) begin
      o_sys_us <= '0;
    end else if (us_tick && (o_sys_us != US_MAX)) begin
      // Saturates while waiting for an external boundary
      o_sys_us <= o_sys_us + 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_sys_secs <= '0;
    end else if (nmea_load) begin
      o_sys_secs <= i_nmea_secs;
    end else if (boundary) begin
      o_sys_secs <= o_sys_secs + 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_full_second <= 1'b0;
    end else begin
      o_full_second <= boundary;
    end
  end

  // ==========================================================================
  // Registered status and configuration outputs
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_src <= SRC_GPS;
      o_nmea_fmt <= NMEA_RMC;
      o_gps_pkt_en <= 1'b0;
      o_gps_port <= GPS_PORT_RST;
      o_ptp_locked <= 1'b0;
    end else begin
      o_src <= cfg_reg.src;
      o_nmea_fmt <= cfg_reg.nmea_fmt;
      o_gps_pkt_en <= (cfg_reg.src == SRC_GPS);
      o_gps_port <= cfg_reg.gps_port;
      o_ptp_locked <= ptp_locked_reg;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_ptp_cfg <= '0;
    end else begin
      o_ptp_cfg.profile <= cfg_reg.profile;
      o_ptp_cfg.transport <= cfg_reg.transport;
      o_ptp_cfg.domain <= cfg_reg.domain;
      o_ptp_cfg.lock_limit_us <= cfg_reg.lock_limit_us;
      o_ptp_cfg.announce_period <= atss_period(cfg_reg.log_announce);
      o_ptp_cfg.sync_period <= atss_period(cfg_reg.log_sync);
      o_ptp_cfg.dreq_period <= atss_period(cfg_reg.log_dreq);
    end
  end

  // ==========================================================================
  // Assertions
  sequence seq_cfg_write(logic signed [EXP_W-1:0] e);
    i_cfg_wr && (i_cfg.log_sync == e);
  endsequence

  sequence seq_pps_edge;
    gps_pps_mode && pps_rise;
  endsequence

  // Second mark and microsecond restart appear together, one cycle after the boundary
  sequence seq_sec_mark;
    o_full_second && (o_sys_us == '0);
  endsequence

  chk_reset_source: assert property (@(posedge i_clk) disable iff (i_rst)
      $past(i_rst) |-> (cfg_reg.src == SRC_GPS) && (o_gps_port == GPS_PORT_RST))
    else $error("source or port wrong after reset");

  chk_pps_us_zero: assert property (@(posedge i_clk) disable iff (i_rst)
      seq_pps_edge |=> seq_sec_mark)
    else $error("microseconds not restarted on pulse");

  chk_nmea_load: assert property (@(posedge i_clk) disable iff (i_rst)
      nmea_load && i_pps_locked |=> (o_sys_secs == $past(i_nmea_secs)))
    else $error("date and time not loaded with both locked");

  chk_pulse_required: assert property (@(posedge i_clk) disable iff (i_rst)
      i_nmea_valid && i_nmea_locked && !i_pps_locked && cfg_reg.pulse_lock_required
      && !boundary |=> $stable(o_sys_secs))
    else $error("loaded time while pulse lock required");

  chk_pulse_optional: assert property (@(posedge i_clk) disable iff (i_rst)
      (cfg_reg.src == SRC_GPS) && i_nmea_valid && i_nmea_locked && !i_pps_locked &&
      !cfg_reg.pulse_lock_required && (i_nmea_kind == cfg_reg.nmea_fmt)
      |=> (o_sys_secs == $past(i_nmea_secs)))
    else $error("time not loaded with pulse lock optional");

  chk_fmt_filter: assert property (@(posedge i_clk) disable iff (i_rst)
      i_nmea_valid && (i_nmea_kind != cfg_reg.nmea_fmt) && !boundary
      |=> $stable(o_sys_secs))
    else $error("sentence of wrong format accepted");

  chk_gps_port: assert property (@(posedge i_clk) disable iff (i_rst)
      (cfg_reg.src == SRC_GPS) && $stable(cfg_reg) |=> o_gps_pkt_en &&
      (o_gps_port == $past(cfg_reg.gps_port)))
    else $error("GPS packet port or enable wrong");

  chk_ptp_suppress: assert property (@(posedge i_clk) disable iff (i_rst)
      (cfg_reg.src == SRC_PTP) [*2] |-> !o_gps_pkt_en)
    else $error("GPS packets output in PTP mode");

  chk_lock_limit: assert property (@(posedge i_clk) disable iff (i_rst)
      o_ptp_locked |-> $past(i_ptp_ofs_abs_us, 2) <= OFS_W'($past(cfg_reg.lock_limit_us, 2)))
    else $error("PTP locked with offset beyond limit");

  chk_limit_range: assert property (@(posedge i_clk) disable iff (i_rst)
      (cfg_reg.lock_limit_us >= LOCK_LIM_MIN) && (cfg_reg.lock_limit_us <= LOCK_LIM_MAX))
    else $error("lock limit outside range");

  chk_xport_profile: assert property (@(posedge i_clk) disable iff (i_rst)
      (o_ptp_cfg.profile == PROF_8021AS) |-> (o_ptp_cfg.transport == XPORT_L2))
    else $error("UDP transport with non-1588v2 profile");

  chk_sync_period: assert property (@(posedge i_clk) disable iff (i_rst)
      seq_cfg_write(4'hf) ##1 !i_cfg_wr |=> (o_ptp_cfg.sync_period == 11'h040))
    else $error("sync period not two to the exponent");

  chk_exp_range: assert property (@(posedge i_clk) disable iff (i_rst)
      (cfg_reg.log_sync >= SYNC_MIN) && (cfg_reg.log_sync <= SYNC_MAX) &&
      (cfg_reg.log_announce >= ANN_MIN) && (cfg_reg.log_announce <= ANN_MAX))
    else $error("interval exponent outside range");

  chk_internal_sec: assert property (@(posedge i_clk) disable iff (i_rst)
      !gps_pps_mode && !ptp_mode && us_wrap && !nmea_load
      |=> (o_sys_secs == $past(o_sys_secs) + 1'b1) && o_full_second && (o_sys_us == '0))
    else $error("internal second not marked");

  chk_unlocked_hold: assert property (@(posedge i_clk) disable iff (i_rst)
      i_nmea_valid && !i_nmea_locked && !i_pps_locked && !boundary
      |=> $stable(o_sys_secs))
    else $error("time updated with both inputs unlocked");

  chk_secs_hold: assert property (@(posedge i_clk) disable iff (i_rst)
      !boundary && !nmea_load |=> $stable(o_sys_secs))
    else $error("seconds changed without boundary or load");

  chk_us_range: assert property (@(posedge i_clk) disable iff (i_rst)
      o_sys_us <= US_MAX)
    else $error("microsecond field beyond one second");

  chk_dreq_range: assert property (@(posedge i_clk) disable iff (i_rst)
      (cfg_reg.log_dreq >= DREQ_MIN) && (cfg_reg.log_dreq <= DREQ_MAX))
    else $error("delay request exponent outside range");

endmodule : atss_time_core

// ### atss_gps_model.sv
// Purpose: Receiver stand-in that drives the PPS pin, the lock levels and parsed sentences.
// Assumes: Driven at the falling edge of i_clk.
// Notes: Released sentence lines show the inverse of the last value.
`timescale 1ns/1ps
module atss_gps_model
  import atss_pkg::*;
(
  input wire logic i_clk,
  output logic o_pps,
  output logic o_pps_locked,
  output logic o_nmea_locked,
  output logic o_nmea_valid,
  output atss_nmea_t o_kind,
  output logic [SECS_W-1:0] o_secs
);
  initial begin
    o_pps = 1'b0;
    o_pps_locked = 1'b0;
    o_nmea_locked = 1'b0;
    o_nmea_valid = 1'b0;
    o_kind = NMEA_RMC;
    o_secs = '0;
  end

  task automatic send(input atss_nmea_t k, input logic [SECS_W-1:0] s);
    @(negedge i_clk);
    o_kind = k;
    o_secs = s;
    o_nmea_valid = 1'b1;
    @(negedge i_clk);
    o_nmea_valid = 1'b0;
    o_kind = atss_nmea_t'(~k);
    o_secs = ~s;
  endtask : send

  task automatic pulse();
    @(negedge i_clk);
    o_pps = 1'b1;
    repeat (4) @(negedge i_clk);
    o_pps = 1'b0;
  endtask : pulse
endmodule : atss_gps_model

// ### atss_time_core_tb.sv
// Purpose: Self-checking bench for the absolute time keeper.
// Assumes: One "second" is shortened to 20 microseconds.
// Notes: Expected time is tracked with integers from the lock table.
`timescale 1ns/1ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin $display("mismatch %s exp %0h got %0h", n, e, g); n_errors++; end end
module atss_time_core_tb;
  import atss_pkg::*;
  localparam int US_SEC = 20;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic cfg_wr = 1'b0;
  atss_cfg_t cfg = CFG_RST;
  logic ofs_valid = 1'b0;
  logic [OFS_W-1:0] ofs = '0;
  logic sec_pulse = 1'b0;
  logic pps, pps_lk, nmea_lk, nmea_v, full_sec, pkt_en, ptp_lk;
  atss_nmea_t kind, fmt;
  atss_src_t src;
  logic [SECS_W-1:0] nsecs, secs;
  logic [US_W-1:0] us;
  logic [PORT_W-1:0] port;
  atss_ptp_cfg_t pcfg;
  int n_errors = 0;
  int num_checks = 0;
  int exp_secs = 0;
  logic [SECS_W-1:0] r;

  always #4 i_clk = ~i_clk;

  atss_gps_model u_atss_gps_model (.i_clk(i_clk), .o_pps(pps), .o_pps_locked(pps_lk),
    .o_nmea_locked(nmea_lk), .o_nmea_valid(nmea_v), .o_kind(kind), .o_secs(nsecs));

  atss_time_core #(.US_PER_SEC(US_SEC)) u_atss_time_core (.i_clk(i_clk), .i_rst(i_rst),
    .i_cfg_wr(cfg_wr), .i_cfg(cfg), .i_pps(pps), .i_pps_locked(pps_lk),
    .i_nmea_locked(nmea_lk), .i_nmea_valid(nmea_v), .i_nmea_kind(kind), .i_nmea_secs(nsecs),
    .i_ptp_ofs_valid(ofs_valid), .i_ptp_ofs_abs_us(ofs), .i_ptp_sec_pulse(sec_pulse),
    .o_src(src), .o_nmea_fmt(fmt), .o_sys_secs(secs), .o_sys_us(us),
    .o_full_second(full_sec), .o_gps_pkt_en(pkt_en), .o_gps_port(port),
    .o_ptp_locked(ptp_lk), .o_ptp_cfg(pcfg));

  // ==========================================================================
  // Tasks
  task automatic summarize();
    if (n_errors == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : summarize

  task automatic write_cfg(input atss_cfg_t c);
    @(negedge i_clk);
    cfg = c;
    cfg_wr = 1'b1;
    @(negedge i_clk);
    cfg_wr = 1'b0;
    repeat (2) @(negedge i_clk);
  endtask : write_cfg

  task automatic wait_sec(input int lim);
    int i;
    for (i = 0; i < lim; i++) begin
      @(negedge i_clk);
      if (full_sec === 1'b1) break;
    end
    `CHK("full_second", 1'b1, full_sec)
    exp_secs++;
    `CHK("sys_secs", exp_secs, secs)
    `CHK("sys_us", 20'h00000, us)
  endtask : wait_sec

  task automatic nmea(input atss_nmea_t k, input bit load);
    r = $urandom;
    u_atss_gps_model.send(k, r);
    @(negedge i_clk);
    if (load) exp_secs = r;
    `CHK("nmea_secs", exp_secs, secs)
  endtask : nmea

  task automatic ptp_check(input int lk);
    `CHK("src", SRC_PTP, src)
    `CHK("pkt_en", 1'b0, pkt_en)
    `CHK("transport", XPORT_L2, pcfg.transport)
    `CHK("limit", lk, pcfg.lock_limit_us)
  endtask : ptp_check

  // ==========================================================================
  // Main sequence
  initial begin
    atss_cfg_t c;
    void'($urandom(32'h5e6bdcf4));
    repeat (10) @(negedge i_clk);
    i_rst = 1'b0;
    repeat (3) @(negedge i_clk);
    `CHK("src", SRC_GPS, src)
    `CHK("port", 16'h277e, port)
    `CHK("pkt_en", 1'b1, pkt_en)
    `CHK("prof", PROF_1588V2, pcfg.profile)
    `CHK("xport", XPORT_UDP, pcfg.transport)
    `CHK("domain", 7'h00, pcfg.domain)
    `CHK("limit", 7'h01, pcfg.lock_limit_us)
    `CHK("ann", 11'h100, pcfg.announce_period)
    `CHK("sync", 11'h100, pcfg.sync_period)
    `CHK("dreq", 11'h080, pcfg.dreq_period)
    wait_sec(3000);
    nmea(NMEA_RMC, 1'b0);
    u_atss_gps_model.o_nmea_locked = 1'b1;
    nmea(NMEA_RMC, 1'b0);
    u_atss_gps_model.o_pps_locked = 1'b1;
    c = CFG_RST;
    for (int k = 0; k < 2; k++) begin
      c.nmea_fmt = atss_nmea_t'(k);
      c.gps_port = 16'($urandom);
      write_cfg(c);
      `CHK("nmea_fmt", c.nmea_fmt, fmt)
      `CHK("port", c.gps_port, port)
      for (int j = 0; j < 2; j++) nmea(atss_nmea_t'(j), j == k);
    end
    fork
      u_atss_gps_model.pulse();
      wait_sec(30);
    join
    c.pulse_lock_required = 1'b0;
    write_cfg(c);
    u_atss_gps_model.o_pps_locked = 1'b0;
    nmea(NMEA_GGA, 1'b1);
    c = CFG_RST;
    c.src = SRC_PTP;
    c.profile = PROF_8021AS;
    c.domain = 7'($urandom_range(127));
    c.lock_limit_us = 7'h00;
    c.log_announce = 4'h8;
    c.log_sync = 4'h3;
    c.log_dreq = 4'h9;
    write_cfg(c);
    ptp_check(1);
    `CHK("domain", c.domain, pcfg.domain)
    `CHK("ann", 11'h020, pcfg.announce_period)
    `CHK("sync", 11'h400, pcfg.sync_period)
    `CHK("dreq", 11'h001, pcfg.dreq_period)
    c.lock_limit_us = 7'h7f;
    c.log_sync = 4'hf;
    write_cfg(c);
    ptp_check(100);
    `CHK("sync", 11'h040, pcfg.sync_period)
    for (int i = 0; i < 2; i++) begin
      ofs_valid = 1'b1;
      ofs = 16'(100 + i);
      repeat (3) @(negedge i_clk);
      `CHK("ptp_locked", i == 0, ptp_lk)
    end
    ofs = 16'h0032;
    repeat (3) @(negedge i_clk);
    sec_pulse = 1'b1;
    fork
      @(negedge i_clk) sec_pulse = 1'b0;
      wait_sec(10);
    join
    summarize();
  end

  initial begin
    #(8 * 20000);
    n_errors++;
    summarize();
  end
endmodule : atss_time_core_tb
